// file: rtl/alu_branch_exec.sv
/*
 * Execution stage for arithmetic, logic, compare, skip and branch operations
 * of a small 8-bit core. Holds the program counter and the status flag byte.
 * Assumes the decode front end presents one operation per start_i pulse with
 * operands already read from the register file and I/O space, and that it
 * waits for done_o before issuing the next one.
 */
`timescale 1ns/100ps

//////////////////////////////////////////////////////////////////////////////

// Overview of operation
// RULE_01 - Register add with or without carry writes sum, sets Z C N V H, one clock
// RULE_02 - Word add/subtract immediate works on the pair, sets Z C N V S, two clocks
// RULE_03 - Subtract register or constant, optional carry, sets Z C N V H, one clock
// RULE_04 - AND, OR, XOR with register or constant set only Z N V, one clock; the code also sets S
// RULE_05 - Clear bits ANDs with 0xFF minus constant; set bits ORs; Z N V updated
// RULE_06 - Zero-or-minus test ANDs register with itself, no write, sets Z N V
// RULE_07 - Pointer jump loads program counter from Z pair, two clocks, no flags
// RULE_08 - Offset call sets PC to PC plus offset plus one, pushes return, three clocks
// RULE_09 - Equal compare skip advances PC two or three on match, no flags
// RULE_10 - Compares subtract without storing and set Z N V C H in one clock
// RULE_11 - Register bit skip jumps next instruction when bit equals tested value
// RULE_12 - I/O bit skip jumps next instruction on match, flags untouched
// RULE_13 - Flag branch adds offset plus one when flag matches; one or two clocks
// RULE_14 - Signed branches decide on N xor V, taken at zero or one
// RULE_15 - Same-or-higher taken on carry clear, lower taken on carry set
// RULE_16 - Interrupt enable branches taken on flag set or clear as selected
// RULE_17 - Transfer bit branches taken when the flag holds the tested value
// RULE_18 - Half-carry branches taken when the flag holds the tested value
// RULE_19 - I/O bit set or clear changes only that bit, no flags, two clocks
// RULE_20 - Skip costs one untaken, two over one word, three over two words
module alu_branch_exec (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic start_i,
    input wire logic [4:0] op_i,
    input wire logic use_imm_i,
    input wire logic [7:0] dest_reg_i,
    input wire logic [7:0] source_reg_i,
    input wire logic [7:0] imm_i,
    input wire logic [15:0] word_pair_i,
    input wire logic [15:0] z_pointer_i,
    input wire logic [11:0] offset_i,
    input wire logic [2:0] bit_sel_i,
    input wire logic test_val_i,
    input wire logic [7:0] io_byte_i,
    input wire logic next_two_word_i,
    input wire logic flags_load_i,
    input wire logic [7:0] flags_in_i,
    output logic [7:0] result_o,
    output logic result_we_o,
    output logic [15:0] word_result_o,
    output logic word_we_o,
    output logic [7:0] io_byte_o,
    output logic io_we_o,
    output logic [15:0] push_addr_o,
    output logic push_we_o,
    output logic [15:0] pc_o,
    output logic [7:0] status_flag_byte_o,
    output logic busy_o,
    output logic done_o
);

    //////////////////////////////////////////////////////////////////////////

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WAIT = 2'b10
    } fsm_e;

    typedef struct packed {
        fsm_e fsm;
        logic [1:0] wait_cnt;
        logic [15:0] pc;
        logic [7:0] flags;
        logic [7:0] result;
        logic result_we;
        logic [15:0] word_result;
        logic word_we;
        logic [7:0] io_byte;
        logic io_we;
        logic [15:0] push_addr;
        logic push_we;
        logic busy;
        logic done;
    } state_s;

    localparam state_s STATE_RST = '{
        fsm: ST_IDLE,
        wait_cnt: 2'h0,
        pc: alu_exec_pkg::PC_RST,
        flags: alu_exec_pkg::FLAGS_RST,
        result: 8'h00,
        result_we: 1'b0,
        word_result: 16'h0000,
        word_we: 1'b0,
        io_byte: 8'h00,
        io_we: 1'b0,
        push_addr: 16'h0000,
        push_we: 1'b0,
        busy: 1'b0,
        done: 1'b0
    };

    state_s s_r;
    state_s s_nxt;

    //////////////////////////////////////////////////////////////////////////
    // Shared 8-bit adder for add, subtract and compare

    alu_exec_pkg::op_e op;
    logic [7:0] operand_b;
    logic is_sub;
    logic use_carry;
    logic [7:0] arith_sum;
    logic arith_c;
    logic arith_h;
    logic arith_v;

    assign op = alu_exec_pkg::op_e'(op_i);
    assign operand_b = use_imm_i ? imm_i : source_reg_i;
    assign is_sub = (op == alu_exec_pkg::OP_SUB) || (op == alu_exec_pkg::OP_SBC)
        || (op == alu_exec_pkg::OP_CMP) || (op == alu_exec_pkg::OP_CMPC);
    assign use_carry = (op == alu_exec_pkg::OP_ADC) || (op == alu_exec_pkg::OP_SBC)
        || (op == alu_exec_pkg::OP_CMPC);

    addsub8 u_addsub8 (
        .a_i(dest_reg_i),
        .b_i(operand_b),
        .cin_i(use_carry & s_r.flags[alu_exec_pkg::FLAG_C]),
        .sub_i(is_sub),
        .sum_o(arith_sum),
        .carry_o(arith_c),
        .half_o(arith_h),
        .ovf_o(arith_v)
    );

    //////////////////////////////////////////////////////////////////////////
    // Next-state helpers, all given a value at the top of the process

    logic [7:0] logic_res;
    logic [16:0] word_res;
    logic [15:0] pc_next_seq;
    logic [15:0] pc_branch;
    logic [15:0] pc_skip;
    logic [1:0] skip_cyc;
    logic [1:0] cyc;
    logic skip_hit;
    logic flag_hit;
    logic wv;
    logic wc;

    always_comb begin
        logic_res = 8'h00;
        word_res = 17'h00000;
        wv = 1'b0;
        wc = 1'b0;
        pc_next_seq = s_r.pc + 16'h0001;
        // Offset arrives sign-extended to 12 bits from decode
        pc_branch = s_r.pc + {{4{offset_i[11]}}, offset_i} + 16'h0001;
        // A skip steps over one or two words; the cost grows with it
        pc_skip = next_two_word_i ? s_r.pc + 16'h0003 : s_r.pc + 16'h0002; // RULE_20
        skip_cyc = next_two_word_i ? alu_exec_pkg::CYC_THREE : alu_exec_pkg::CYC_TWO; // RULE_20
        skip_hit = 1'b0;
        flag_hit = (s_r.flags[bit_sel_i] == test_val_i); // RULE_15
        cyc = alu_exec_pkg::CYC_ONE;
        s_nxt = s_r;
        s_nxt.result_we = 1'b0;
        s_nxt.word_we = 1'b0;
        s_nxt.io_we = 1'b0;
        s_nxt.push_we = 1'b0;
        s_nxt.done = 1'b0;

        case (s_r.fsm)
            ST_IDLE: begin
                if (start_i) begin
                    s_nxt.pc = pc_next_seq;
                    case (op)
                        alu_exec_pkg::OP_ADD, alu_exec_pkg::OP_ADC,
                        alu_exec_pkg::OP_SUB, alu_exec_pkg::OP_SBC,
                        alu_exec_pkg::OP_CMP, alu_exec_pkg::OP_CMPC: begin
                            // Compares share the subtractor but never write back
                            s_nxt.result = arith_sum; // RULE_01
                            s_nxt.result_we = !(op == alu_exec_pkg::OP_CMP
                                || op == alu_exec_pkg::OP_CMPC); // RULE_10
                            s_nxt.flags[alu_exec_pkg::FLAG_C] = arith_c; // RULE_03
                            s_nxt.flags[alu_exec_pkg::FLAG_H] = arith_h; // RULE_01
                            s_nxt.flags[alu_exec_pkg::FLAG_V] = arith_v; // RULE_03
                            s_nxt.flags[alu_exec_pkg::FLAG_N] = arith_sum[7]; // RULE_10
                            s_nxt.flags[alu_exec_pkg::FLAG_S] = arith_sum[7] ^ arith_v;
                            // Carry-chained subtract keeps Z across a multi-byte compare
                            if (is_sub && use_carry) begin
                                s_nxt.flags[alu_exec_pkg::FLAG_Z] = (arith_sum == 8'h00)
                                    & s_r.flags[alu_exec_pkg::FLAG_Z]; // RULE_10
                            end else begin
                                s_nxt.flags[alu_exec_pkg::FLAG_Z] =
                                    (arith_sum == 8'h00); // RULE_01
                            end
                        end
                        alu_exec_pkg::OP_AND, alu_exec_pkg::OP_OR, alu_exec_pkg::OP_EOR,
                        alu_exec_pkg::OP_CLRBITS, alu_exec_pkg::OP_SETBITS,
                        alu_exec_pkg::OP_TEST: begin
                            case (op)
                                alu_exec_pkg::OP_AND: logic_res = dest_reg_i & operand_b; // RULE_04
                                alu_exec_pkg::OP_OR: logic_res = dest_reg_i | operand_b; // RULE_04
                                alu_exec_pkg::OP_EOR: logic_res = dest_reg_i ^ operand_b; // RULE_04
                                alu_exec_pkg::OP_CLRBITS: begin
                                    logic_res = dest_reg_i
                                        & (alu_exec_pkg::CLR_MASK_BASE - imm_i); // RULE_05
                                end
                                alu_exec_pkg::OP_SETBITS: logic_res = dest_reg_i | imm_i; // RULE_05
                                default: logic_res = dest_reg_i & dest_reg_i; // RULE_06
                            endcase
                            s_nxt.result = logic_res;
                            // The test leaves the register as it was
                            s_nxt.result_we = (op != alu_exec_pkg::OP_TEST); // RULE_06
                            s_nxt.flags[alu_exec_pkg::FLAG_Z] = (logic_res == 8'h00); // RULE_04
                            s_nxt.flags[alu_exec_pkg::FLAG_N] = logic_res[7]; // RULE_04
                            s_nxt.flags[alu_exec_pkg::FLAG_V] = 1'b0; // RULE_04
                            s_nxt.flags[alu_exec_pkg::FLAG_S] = logic_res[7];
                        end
                        alu_exec_pkg::OP_WORD_ADD, alu_exec_pkg::OP_WORD_SUB: begin
                            if (op == alu_exec_pkg::OP_WORD_ADD) begin
                                word_res = {1'b0, word_pair_i} + {9'h000, imm_i}; // RULE_02
                                wv = ~word_pair_i[15] & word_res[15];
                                wc = ~word_res[15] & word_pair_i[15];
                            end else begin
                                word_res = {1'b0, word_pair_i} - {9'h000, imm_i}; // RULE_02
                                wv = word_pair_i[15] & ~word_res[15];
                                wc = word_res[15] & ~word_pair_i[15];
                            end
                            s_nxt.word_result = word_res[15:0];
                            s_nxt.word_we = 1'b1;
                            s_nxt.flags[alu_exec_pkg::FLAG_Z] = (word_res[15:0] == 16'h0000);
                            s_nxt.flags[alu_exec_pkg::FLAG_C] = wc; // RULE_02
                            s_nxt.flags[alu_exec_pkg::FLAG_N] = word_res[15]; // RULE_02
                            s_nxt.flags[alu_exec_pkg::FLAG_V] = wv; // RULE_02
                            s_nxt.flags[alu_exec_pkg::FLAG_S] = word_res[15] ^ wv; // RULE_02
                            cyc = alu_exec_pkg::CYC_TWO; // RULE_02
                        end
                        alu_exec_pkg::OP_REL_JUMP: begin
                            s_nxt.pc = pc_branch;
                            cyc = alu_exec_pkg::CYC_TWO;
                        end
                        alu_exec_pkg::OP_PTR_JUMP: begin
                            s_nxt.pc = z_pointer_i; // RULE_07
                            cyc = alu_exec_pkg::CYC_TWO; // RULE_07
                        end
                        alu_exec_pkg::OP_OFS_CALL: begin
                            s_nxt.pc = pc_branch; // RULE_08
                            s_nxt.push_addr = pc_next_seq; // RULE_08
                            s_nxt.push_we = 1'b1; // RULE_08
                            cyc = alu_exec_pkg::CYC_THREE; // RULE_08
                        end
                        alu_exec_pkg::OP_EQ_SKIP, alu_exec_pkg::OP_REGBIT_SKIP,
                        alu_exec_pkg::OP_IOBIT_SKIP: begin
                            case (op)
                                alu_exec_pkg::OP_EQ_SKIP: begin
                                    skip_hit = (dest_reg_i == source_reg_i); // RULE_09
                                end
                                alu_exec_pkg::OP_REGBIT_SKIP: begin
                                    skip_hit = (source_reg_i[bit_sel_i] == test_val_i); // RULE_11
                                end
                                default: skip_hit = (io_byte_i[bit_sel_i] == test_val_i); // RULE_12
                            endcase
                            // Skips leave every flag alone
                            if (skip_hit) begin
                                s_nxt.pc = pc_skip; // RULE_09
                                cyc = skip_cyc; // RULE_20
                            end
                        end
                        alu_exec_pkg::OP_FLAG_BRANCH: begin
                            // One path serves carry, interrupt enable, T and H selects
                            if (flag_hit) begin // RULE_16 RULE_17 RULE_18
                                s_nxt.pc = pc_branch; // RULE_13
                                cyc = alu_exec_pkg::CYC_TWO; // RULE_13
                            end
                        end
                        alu_exec_pkg::OP_SIGN_BRANCH: begin
                            if ((s_r.flags[alu_exec_pkg::FLAG_N]
                                ^ s_r.flags[alu_exec_pkg::FLAG_V]) == test_val_i) begin // RULE_14
                                s_nxt.pc = pc_branch; // RULE_14
                                cyc = alu_exec_pkg::CYC_TWO; // RULE_13
                            end
                        end
                        alu_exec_pkg::OP_IOBIT_SET, alu_exec_pkg::OP_IOBIT_CLR: begin
                            // Only the chosen bit moves; the whole byte is written back as read, set write-one-to-clear flags included
                            s_nxt.io_byte = io_byte_i;
                            s_nxt.io_byte[bit_sel_i] = (op == alu_exec_pkg::OP_IOBIT_SET); // RULE_19
                            s_nxt.io_we = 1'b1; // RULE_19
                            cyc = alu_exec_pkg::CYC_TWO; // RULE_19
                        end
                        default: begin
                            cyc = alu_exec_pkg::CYC_ONE;
                        end
                    endcase
                    if (cyc == alu_exec_pkg::CYC_ONE) begin
                        s_nxt.done = 1'b1;
                    end else begin
                        s_nxt.fsm = ST_WAIT;
                        s_nxt.busy = 1'b1;
                        s_nxt.wait_cnt = cyc - 2'h1;
                    end
                end else if (flags_load_i) begin
                    s_nxt.flags = flags_in_i;
                end
            end
            ST_WAIT: begin
                // Extra clocks of a multi-cycle operation; requests are ignored
                s_nxt.wait_cnt = s_r.wait_cnt - 2'h1;
                if (s_r.wait_cnt == 2'h1) begin
                    s_nxt.fsm = ST_IDLE;
                    s_nxt.busy = 1'b0;
                    s_nxt.done = 1'b1;
                end
            end
            default: begin
                s_nxt = STATE_RST;
            end
        endcase
    end

    //////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            s_r <= STATE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign result_o = s_r.result;
    assign result_we_o = s_r.result_we;
    assign word_result_o = s_r.word_result;
    assign word_we_o = s_r.word_we;
    assign io_byte_o = s_r.io_byte;
    assign io_we_o = s_r.io_we;
    assign push_addr_o = s_r.push_addr;
    assign push_we_o = s_r.push_we;
    assign pc_o = s_r.pc;
    assign status_flag_byte_o = s_r.flags;
    assign busy_o = s_r.busy;
    assign done_o = s_r.done;

endmodule

// file: include/alu_exec_pkg.sv
/*
 * Shared constants for the ALU and branch execution block: operation codes,
 * status flag bit positions, reset values and per-operation cycle counts.
 * Assumes the decode front end maps each instruction onto one op_e code.
 */
package alu_exec_pkg;

    localparam int PC_W = 16;

    // Status flag byte bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // Reset values
    localparam logic [PC_W-1:0] PC_RST = 16'h0000;
    localparam logic [7:0] FLAGS_RST = 8'h00;

    // Bit mask base for clearing selected bits
    localparam logic [7:0] CLR_MASK_BASE = 8'hff;

    // Cycle counts
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;

    typedef enum logic [4:0] {
        OP_NOP = 5'h00,
        OP_ADD = 5'h01,
        OP_ADC = 5'h02,
        OP_SUB = 5'h03,
        OP_SBC = 5'h04,
        OP_AND = 5'h05,
        OP_OR = 5'h06,
        OP_EOR = 5'h07,
        OP_CLRBITS = 5'h08,
        OP_SETBITS = 5'h09,
        OP_TEST = 5'h0a,
        OP_CMP = 5'h0b,
        OP_CMPC = 5'h0c,
        OP_WORD_ADD = 5'h0d,
        OP_WORD_SUB = 5'h0e,
        OP_REL_JUMP = 5'h0f,
        OP_PTR_JUMP = 5'h10,
        OP_OFS_CALL = 5'h11,
        OP_EQ_SKIP = 5'h12,
        OP_REGBIT_SKIP = 5'h13,
        OP_IOBIT_SKIP = 5'h14,
        OP_FLAG_BRANCH = 5'h15,
        OP_SIGN_BRANCH = 5'h16,
        OP_IOBIT_SET = 5'h17,
        OP_IOBIT_CLR = 5'h18
    } op_e;

endpackage

// file: rtl/addsub8.sv
/*
 * Eight-bit adder/subtractor with carry-in and the carry, half-carry and
 * overflow terms of the status flag byte. Purely combinational; the caller
 * registers the results.
 */
`timescale 1ns/100ps

module addsub8 (
    input wire logic [7:0] a_i,
    input wire logic [7:0] b_i,
    input wire logic cin_i,
    input wire logic sub_i,
    output logic [7:0] sum_o,
    output logic carry_o,
    output logic half_o,
    output logic ovf_o
);

    logic [7:0] r;

    always_comb begin
        if (sub_i) begin
            r = a_i - b_i - {7'h00, cin_i};
            // Borrow terms: carry and half carry mean borrow on subtract
            carry_o = (~a_i[7] & b_i[7]) | (b_i[7] & r[7]) | (r[7] & ~a_i[7]);
            half_o = (~a_i[3] & b_i[3]) | (b_i[3] & r[3]) | (r[3] & ~a_i[3]);
            ovf_o = (a_i[7] & ~b_i[7] & ~r[7]) | (~a_i[7] & b_i[7] & r[7]);
        end else begin
            r = a_i + b_i + {7'h00, cin_i};
            carry_o = (a_i[7] & b_i[7]) | (b_i[7] & ~r[7]) | (~r[7] & a_i[7]);
            half_o = (a_i[3] & b_i[3]) | (b_i[3] & ~r[3]) | (~r[3] & a_i[3]);
            ovf_o = (a_i[7] & b_i[7] & ~r[7]) | (~a_i[7] & ~b_i[7] & r[7]);
        end
        sum_o = r;
    end

endmodule

// file: testbench/alu_exec_chk.sv
/*
 * Port-level checker for alu_branch_exec.
 * Assumes a bind into it; sees only its ports.
 */
`timescale 1ns/100ps

module alu_exec_chk (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic start_i,
    input wire logic [4:0] op_i,
    input wire logic [7:0] dest_reg_i,
    input wire logic [7:0] source_reg_i,
    input wire logic [15:0] z_pointer_i,
    input wire logic [11:0] offset_i,
    input wire logic [2:0] bit_sel_i,
    input wire logic test_val_i,
    input wire logic [7:0] io_byte_i,
    input wire logic next_two_word_i,
    input wire logic result_we_o,
    input wire logic word_we_o,
    input wire logic [7:0] io_byte_o,
    input wire logic io_we_o,
    input wire logic [15:0] push_addr_o,
    input wire logic push_we_o,
    input wire logic [15:0] pc_o,
    input wire logic [7:0] status_flag_byte_o,
    input wire logic busy_o,
    input wire logic done_o
);
default clocking cb @(posedge clk_sys_i); endclocking
default disable iff (!resetn_i);
// Starts while busy are dropped
wire issue = start_i && !busy_o;
wire [15:0] ofs_x = {{4{offset_i[11]}}, offset_i};
//////////////////////////////////////////////////////////////////////////////
property p_one_clk;
    issue && op_i inside {[5'h01:5'h0c]} |=> done_o && !busy_o;
endproperty
a_one_clk: assert property (p_one_clk) else $error("one-clock op late");
property p_writes;
    issue && op_i inside {[5'h01:5'h09]} |=> result_we_o;
endproperty
a_writes: assert property (p_writes) else $error("result not written");
property p_no_write;
    issue && op_i inside {5'h0a, 5'h0b, 5'h0c} |=> !result_we_o;
endproperty
a_no_write: assert property (p_no_write) else $error("test or compare wrote");
property p_word;
    issue && op_i inside {5'h0d, 5'h0e} |=> word_we_o && busy_o && !done_o ##1 done_o;
endproperty
a_word: assert property (p_word) else $error("word op timing wrong");
property p_ptr;
    issue && op_i == 5'h10 |=> pc_o == $past(z_pointer_i) && $stable(status_flag_byte_o)
        ##1 done_o;
endproperty
a_ptr: assert property (p_ptr) else $error("pointer jump wrong");
property p_call;
    issue && op_i == 5'h11 |=> push_we_o && push_addr_o == $past(pc_o) + 16'h1
        && pc_o == $past(pc_o) + $past(ofs_x) + 16'h1 ##1 !done_o ##1 done_o;
endproperty
a_call: assert property (p_call) else $error("offset call wrong");
property p_eq_skip;
    issue && op_i == 5'h12 && dest_reg_i == source_reg_i
        |=> pc_o == $past(pc_o) + ($past(next_two_word_i) ? 16'h3 : 16'h2);
endproperty
a_eq_skip: assert property (p_eq_skip) else $error("equal skip pc wrong");
property p_branch;
    issue && op_i == 5'h15 && status_flag_byte_o[bit_sel_i] == test_val_i
        |=> pc_o == $past(pc_o) + $past(ofs_x) + 16'h1 && busy_o;
endproperty
a_branch: assert property (p_branch) else $error("flag branch not taken");
property p_sign;
    issue && op_i == 5'h16 && (status_flag_byte_o[2] ^ status_flag_byte_o[3]) != test_val_i
        |=> pc_o == $past(pc_o) + 16'h1 && done_o;
endproperty
a_sign: assert property (p_sign) else $error("signed branch taken wrongly");
property p_iobit;
    issue && op_i == 5'h17 |=> io_we_o && io_byte_o == ($past(io_byte_i) | (8'h01 <<
        $past(bit_sel_i))) ##1 done_o;
endproperty
a_iobit: assert property (p_iobit) else $error("io bit set wrong");
c_call: cover property (issue && op_i == 5'h11);
c_skip: cover property (issue && op_i == 5'h13 ##1 busy_o);
c_branch: cover property (issue && op_i == 5'h15 ##1 busy_o);
endmodule

bind alu_branch_exec alu_exec_chk u_chk (.*);

// file: testbench/test_cpu_alu_branch_exec.sv
/*
 * Bench for alu_branch_exec: one operation at a time, hand-worked values.
 * Assumes the package is compiled first.
 */
`timescale 1ns/100ps

module test_cpu_alu_branch_exec;
logic clk_sys_i = 1'b0, resetn_i = 1'b0, start_i = 1'b0, use_imm_i = 1'b0;
logic test_val_i = 1'b0, next_two_word_i = 1'b0, flags_load_i = 1'b0;
logic [4:0] op_i = 5'h00;
logic [7:0] dest_reg_i = 8'h00, source_reg_i = 8'h00, imm_i = 8'h00, io_byte_i = 8'h00;
logic [7:0] flags_in_i = 8'h00, result_o, io_byte_o, status_flag_byte_o;
logic [15:0] word_pair_i = 16'h0000, z_pointer_i = 16'h0000, word_result_o, push_addr_o;
logic [15:0] pc_o, pc_e = 16'h0000;
logic [11:0] offset_i = 12'h000;
logic [2:0] bit_sel_i = 3'h0;
logic result_we_o, word_we_o, io_we_o, push_we_o, busy_o, done_o;
int fail_count = 0;
int cmp_count = 0;

alu_branch_exec u_dut (.*);

always #20 clk_sys_i = ~clk_sys_i;
//////////////////////////////////////////////////////////////////////////////
task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
        fail_count++;
        $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
endtask

task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
endtask

// An idle cycle separates issues
task automatic exec(input logic [4:0] op, input logic [7:0] a, input logic [7:0] b,
    input int ncyc, input logic [15:0] dpc, input logic [7:0] fl);
    int n;
    @(posedge clk_sys_i);
    start_i <= 1'b1;
    op_i <= op;
    dest_reg_i <= a;
    source_reg_i <= b;
    @(posedge clk_sys_i);
    start_i <= 1'b0;
    #1;
    n = 1;
    while (done_o !== 1'b1 && n < 8) begin
        @(posedge clk_sys_i);
        #1;
        n++;
    end
    if (n >= 8) begin
        fail_count++;
        summarize();
    end
    pc_e = pc_e + dpc;
    chk("cycles", 16'(ncyc), 16'(n));
    chk("pc", pc_e, pc_o);
    chk("flags", 16'(fl), 16'(status_flag_byte_o));
endtask

task automatic load_flags(input logic [7:0] v);
    @(posedge clk_sys_i);
    flags_load_i <= 1'b1;
    flags_in_i <= v;
    @(posedge clk_sys_i);
    flags_load_i <= 1'b0;
    #1;
    chk("flag load", 16'(v), 16'(status_flag_byte_o));
endtask
//////////////////////////////////////////////////////////////////////////////
initial begin
    logic tk;
    logic [7:0] fv;
    repeat (3) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    chk("reset pc", 16'h0000, pc_o);
    chk("reset flags", 16'h0000, 16'(status_flag_byte_o));
    exec(alu_exec_pkg::OP_ADD, 8'h78, 8'h08, 1, 16'h1, 8'h2c);
    chk("sum", 16'h0080, 16'(result_o));
    exec(alu_exec_pkg::OP_ADD, 8'hff, 8'h01, 1, 16'h1, 8'h23);
    exec(alu_exec_pkg::OP_ADC, 8'h10, 8'h20, 1, 16'h1, 8'h00);
    chk("sum carry", 16'h0031, 16'(result_o));
    use_imm_i <= 1'b1;
    imm_i <= 8'h01;
    exec(alu_exec_pkg::OP_SUB, 8'h10, 8'h00, 1, 16'h1, 8'h20);
    chk("diff imm", 16'h000f, 16'(result_o));
    use_imm_i <= 1'b0;
    exec(alu_exec_pkg::OP_SUB, 8'h00, 8'h01, 1, 16'h1, 8'h35);
    exec(alu_exec_pkg::OP_SBC, 8'h05, 8'h02, 1, 16'h1, 8'h00);
    chk("diff carry", 16'h0002, 16'(result_o));
    exec(alu_exec_pkg::OP_AND, 8'hf0, 8'h8f, 1, 16'h1, 8'h14);
    exec(alu_exec_pkg::OP_OR, 8'h00, 8'h00, 1, 16'h1, 8'h02);
    exec(alu_exec_pkg::OP_EOR, 8'ha5, 8'h0f, 1, 16'h1, 8'h14);
    chk("xor", 16'h00aa, 16'(result_o));
    use_imm_i <= 1'b1;
    imm_i <= 8'h81;
    exec(alu_exec_pkg::OP_CLRBITS, 8'hff, 8'h00, 1, 16'h1, 8'h00);
    chk("clear bits", 16'h007e, 16'(result_o));
    imm_i <= 8'h80;
    exec(alu_exec_pkg::OP_SETBITS, 8'h00, 8'h00, 1, 16'h1, 8'h14);
    chk("set bits", 16'h0080, 16'(result_o));
    use_imm_i <= 1'b0;
    exec(alu_exec_pkg::OP_TEST, 8'h00, 8'h00, 1, 16'h1, 8'h02);
    chk("test write", 16'h0000, 16'(result_we_o));
    exec(alu_exec_pkg::OP_CMP, 8'h10, 8'h20, 1, 16'h1, 8'h15);
    exec(alu_exec_pkg::OP_CMPC, 8'h20, 8'h1f, 1, 16'h1, 8'h20);
    chk("compare write", 16'h0000, 16'(result_we_o));
    $display("test arith and logic done");
    use_imm_i <= 1'b1;
    imm_i <= 8'h01;
    word_pair_i <= 16'hffff;
    exec(alu_exec_pkg::OP_WORD_ADD, 8'h00, 8'h00, 2, 16'h1, 8'h23);
    chk("word sum", 16'h0000, word_result_o);
    word_pair_i <= 16'h0000;
    exec(alu_exec_pkg::OP_WORD_SUB, 8'h00, 8'h00, 2, 16'h1, 8'h35);
    chk("word diff", 16'hffff, word_result_o);
    z_pointer_i <= 16'h1234;
    exec(alu_exec_pkg::OP_PTR_JUMP, 8'h00, 8'h00, 2, 16'h1234 - pc_e, 8'h35);
    offset_i <= 12'hffe;
    exec(alu_exec_pkg::OP_OFS_CALL, 8'h00, 8'h00, 3, 16'hffff, 8'h35);
    chk("return addr", 16'h1235, push_addr_o);
    $display("test word and jump done");
    bit_sel_i <= 3'h3;
    io_byte_i <= 8'h08;
    for (int k = 0; k < 12; k++) begin
        tk = k[0];
        test_val_i <= tk;
        next_two_word_i <= k[1];
        exec(5'(alu_exec_pkg::OP_EQ_SKIP + k / 4), 8'h55, (k < 4) ? {7'h2a, tk} : 8'h08,
            tk ? (k[1] ? 3 : 2) : 1, tk ? (k[1] ? 16'h3 : 16'h2) : 16'h1,
            8'h35);
    end
    $display("test skips done");
    load_flags(8'ha5);
    offset_i <= 12'hffd;
    for (int k = 0; k < 16; k++) begin
        tk = (8'ha5 >> k[3:1]) & 8'h01 ? k[0] : !k[0];
        bit_sel_i <= k[3:1];
        test_val_i <= k[0];
        exec(alu_exec_pkg::OP_FLAG_BRANCH, 8'h00, 8'h00, tk ? 2 : 1, tk ? 16'hfffe : 16'h1,
            8'ha5);
    end
    for (int k = 0; k < 4; k++) begin
        fv = k[1] ? 8'h0c : 8'h04;
        load_flags(fv);
        tk = (fv[2] ^ fv[3]) == k[0];
        test_val_i <= k[0];
        exec(alu_exec_pkg::OP_SIGN_BRANCH, 8'h00, 8'h00, tk ? 2 : 1, tk ? 16'hfffe : 16'h1,
            fv);
    end
    exec(alu_exec_pkg::OP_REL_JUMP, 8'h00, 8'h00, 2, 16'hfffe, 8'h0c);
    $display("test branches done");
    io_byte_i <= 8'h5a;
    bit_sel_i <= 3'h0;
    exec(alu_exec_pkg::OP_IOBIT_SET, 8'h00, 8'h00, 2, 16'h1, 8'h0c);
    chk("io set", 16'h005b, 16'(io_byte_o));
    bit_sel_i <= 3'h3;
    exec(alu_exec_pkg::OP_IOBIT_CLR, 8'h00, 8'h00, 2, 16'h1, 8'h0c);
    chk("io clear", 16'h0052, 16'(io_byte_o));
    $display("test io bits done");
    summarize();
end
endmodule
